//--- design/cmpcp_cfg.svh
// Purpose: Constants of the compass command port
// Assumes: 50 MHz core clock
// Notes: Times in ms, cycle counts derived in the module
`ifndef CMPCP_CFG_SVH
`define CMPCP_CFG_SVH
`define CMPCP_CLK_HZ 50000000
`define CMPCP_INIT_MS 500
`define CMPCP_P1HZ_MS 1000
`define CMPCP_P5HZ_MS 200
`define CMPCP_P10HZ_MS 100
`define CMPCP_ADDR_WR 8'h32
`define CMPCP_ADDR_RD 8'h33
`define CMPCP_CMD_HEAD 8'h50
`define CMPCP_CMD_MODE1 8'h65
`define CMPCP_CMD_CAL_IN 8'h71
`define CMPCP_CMD_LEVEL 8'h72
`define CMPCP_CMD_EDGE 8'h73
`define CMPCP_CMD_FRONT 8'h74
`define CMPCP_CMD_RUN 8'h75
`define CMPCP_CMD_STBY 8'h76
`define CMPCP_CMD_CAL_OUT 8'h7e
`define CMPCP_CMD_RESET 8'h82
`define CMPCP_CMD_SLEEP 8'h83
`define CMPCP_CMD_WAKE 8'h84
`define CMPCP_CMD_EE_RD 8'he1
`define CMPCP_CMD_EE_WR 8'hf1
`define CMPCP_EE_MODE1 8'h04
`define CMPCP_EE_MODE2 8'h05
`define CMPCP_M1_FILT 5
`define CMPCP_ORIENT_LEVEL 3'h1
`define CMPCP_ORIENT_EDGE 3'h2
`define CMPCP_ORIENT_FRONT 3'h4
`define CMPCP_MODE2_RESET 8'h01
`define CMPCP_RATE_1HZ 2'h0
`define CMPCP_RATE_5HZ 2'h1
`define CMPCP_RATE_10HZ 2'h2
`define CMPCP_HEAD_MAX 16'h0e10
`define CMPCP_TILT_MAX 16'sh0384
`endif

//--- design/cmpcp_pkg.sv
// Purpose: Types of the compass command port
// Assumes: Nothing
// Notes: Angles in tenths of a degree
package cmpcp_pkg;
    typedef enum {
        CMPCP_IDLE, CMPCP_ADDR, CMPCP_WR, CMPCP_ACK, CMPCP_RD, CMPCP_RACK
    } cmpcp_state_type;
    typedef struct packed {
        logic [15:0] heading;
        logic signed [15:0] pitch;
        logic signed [15:0] roll;
    } cmpcp_angles_type;
    typedef struct packed {
        logic [2:0][15:0] axis;
    } cmpcp_mag_type;
endpackage : cmpcp_pkg

//--- design/cmpcp_top.sv
// Purpose: I2C command port and mode control of a compass module
// Assumes: SCL and SDA asynchronous, sampled by clk_i
// Notes: SDA is open drain, pulled low only
//
// What this block does
// - Mode 1 bit 7 is read-only, set while compass output is computed.
// - Mode 1 bit 6 is read-only, set while calibration runs.
// - Mode 1 bit 5 enables an IIR smoothing filter on heading.
// - Bit 4 shows run, bit 3 standby; run is the default.
// - Bits 2..0 show front, edge, level orientation; level default.
// - Mode 2 low bits pick 1, 5 or 10 Hz; 5 Hz default.
// - Command 71 enters calibration except in sleep, command 7e leaves it.
// - Calibration tracks per-axis field extremes; leaving it updates offsets.
// - First command waits 500 ms; device then comes up in run.
// - Read with 33 returns six bytes, pairs high byte first.
// - Tenths of degree: heading 0..3600, pitch and roll within 900.
// - Wake command returns from sleep into standby, not run.
// - Commands 72, 73, 74 pick level, sideways, front orientation.
// - Command 75 goes standby to run, 76 run to standby.
`timescale 1ns/1ns
`include "cmpcp_cfg.svh"
module cmpcp_top
    import cmpcp_pkg::*;
#(
    parameter int INIT_CYC = `CMPCP_CLK_HZ / 1000 * `CMPCP_INIT_MS,
    parameter int P1_CYC = `CMPCP_CLK_HZ / 1000 * `CMPCP_P1HZ_MS,
    parameter int P5_CYC = `CMPCP_CLK_HZ / 1000 * `CMPCP_P5HZ_MS,
    parameter int P10_CYC = `CMPCP_CLK_HZ / 1000 * `CMPCP_P10HZ_MS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire cmpcp_angles_type angles_i,
    input wire cmpcp_mag_type mag_i,
    output logic meas_tick_o,
    output logic filter_en_o,
    output logic cal_active_o,
    output logic offset_update_o,
    output cmpcp_mag_type mag_offset_o,
    output logic init_done_o,
    output logic [7:0] mode1_o,
    output logic [7:0] mode2_o
);
    logic [1:0] scl_sy_q, sda_sy_q;
    logic scl_p_q, sda_p_q;
    cmpcp_state_type st_q;
    logic [3:0] bcnt_q;
    logic [7:0] sh_q;
    logic drv_q, is_rd_q;
    logic [2:0] ridx_q;
    logic [1:0] widx_q;
    logic [7:0] cmd_q;
    logic [7:0] resp_q [6];
    logic run_q, stby_q, cal_q, filt_q, done_q, upd_q, tick_q;
    logic [2:0] orient_q;
    logic [7:0] mode2_q;
    logic [25:0] init_cnt_q, per_cnt_q;
    cmpcp_angles_type ang_q;
    cmpcp_mag_type off_q;
    logic [15:0] mn_q [3];
    logic [15:0] mx_q [3];

    wire scl_s = scl_sy_q[1];
    wire sda_s = sda_sy_q[1];
    wire rise = scl_s & ~scl_p_q;
    wire fall = ~scl_s & scl_p_q;
    wire start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire byte_end = fall & (bcnt_q == 4'h8);
    wire addr_wr = (st_q == CMPCP_ADDR) & byte_end & done_q
        & (sh_q == `CMPCP_ADDR_WR);
    wire addr_rd = (st_q == CMPCP_ADDR) & byte_end & done_q
        & (sh_q == `CMPCP_ADDR_RD);
    wire wr_stb = (st_q == CMPCP_WR) & byte_end;
    wire rd_load = fall & ((st_q == CMPCP_ACK & is_rd_q)
        | st_q == CMPCP_RACK);
    wire [7:0] rd_byte = resp_q[(ridx_q > 3'h5) ? 3'h5 : ridx_q];
    wire sleep = ~run_q & ~stby_q;
    wire comp = done_q & run_q & ~cal_q;
    wire [7:0] mode1 = {comp, cal_q, filt_q, run_q, stby_q,
        orient_q};
    wire [1:0] rate = mode2_q[1:0];
    wire [25:0] per_lim = (rate == `CMPCP_RATE_1HZ) ? 26'(P1_CYC - 1) :
        (rate == `CMPCP_RATE_10HZ) ? 26'(P10_CYC - 1) :
        26'(P5_CYC - 1); // unassigned code runs at 5 Hz
    // At or past the limit, so a drop to a faster rate cannot overrun
    wire tick = done_q & run_q & (per_cnt_q >= per_lim);
    wire [7:0] cmd0 = sh_q;
    wire soft_rst = wr_stb & (widx_q == 2'h0)
        & (cmd0 == `CMPCP_CMD_RESET);

    function automatic logic [15:0] sat_tilt(input logic [15:0] v);
        if ($signed(v) > `CMPCP_TILT_MAX) return `CMPCP_TILT_MAX;
        if ($signed(v) < -`CMPCP_TILT_MAX) return -`CMPCP_TILT_MAX;
        return v;
    endfunction : sat_tilt

    // Heading filter: quarter-step IIR, limited to the legal range
    wire [16:0] hdiff = {1'b0, angles_i.heading} - {1'b0, ang_q.heading};
    wire [15:0] hfilt = ang_q.heading + {{2{hdiff[16]}}, hdiff[15:2]};
    wire [15:0] hsel = filt_q ? hfilt : angles_i.heading;
    wire [15:0] hsat = (hsel > `CMPCP_HEAD_MAX) ? `CMPCP_HEAD_MAX : hsel;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[0], scl_i};
            sda_sy_q <= {sda_sy_q[0], sda_i};
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // I2C slave; data changes only after SCL falls
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_q <= CMPCP_IDLE;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            drv_q <= 1'b0;
            is_rd_q <= 1'b0;
            ridx_q <= 3'h0;
        end else if (start) begin
            st_q <= CMPCP_ADDR;
            bcnt_q <= 4'h0;
            drv_q <= 1'b0;
        end else if (stop) begin
            st_q <= CMPCP_IDLE;
            drv_q <= 1'b0;
        end else if (rd_load) begin
            st_q <= CMPCP_RD;
            sh_q <= rd_byte;
            drv_q <= ~rd_byte[7];
            ridx_q <= ridx_q + 3'h1;
            bcnt_q <= 4'h0;
        end else begin
            case (st_q)
                CMPCP_ADDR, CMPCP_WR: begin
                    if (rise && bcnt_q != 4'h8) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bcnt_q <= bcnt_q + 4'h1;
                    end
                    if (byte_end) begin
                        bcnt_q <= 4'h0;
                        // No answer to the address until init is over
                        drv_q <= addr_wr | addr_rd | wr_stb;
                        st_q <= (addr_wr | addr_rd | wr_stb) ?
                            CMPCP_ACK : CMPCP_IDLE;
                        if (addr_wr | addr_rd) begin
                            is_rd_q <= addr_rd;
                            ridx_q <= 3'h0;
                        end
                    end
                end
                CMPCP_ACK: begin
                    if (fall) begin
                        st_q <= CMPCP_WR;
                        drv_q <= 1'b0;
                    end
                end
                CMPCP_RD: begin
                    if (fall && bcnt_q == 4'h7) begin
                        st_q <= CMPCP_RACK;
                        drv_q <= 1'b0;
                    end else if (fall) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        drv_q <= ~sh_q[6];
                        bcnt_q <= bcnt_q + 4'h1;
                    end
                end
                CMPCP_RACK: begin
                    if (rise && sda_s) begin
                        st_q <= CMPCP_IDLE;
                    end
                end
                default: begin
                    drv_q <= 1'b0;
                end
            endcase
        end
    end

    // Power-up and soft reset wait; device starts in run mode
    always_ff @(posedge clk_i) begin
        if (!nrst_i || soft_rst) begin
            init_cnt_q <= 26'h0;
            done_q <= 1'b0;
        end else if (!done_q) begin
            done_q <= (init_cnt_q == 26'(INIT_CYC - 1));
            init_cnt_q <= init_cnt_q + 26'h1;
        end
    end

    // Measurement rate divider
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !(done_q && run_q) || tick) begin
            per_cnt_q <= 26'h0;
        end else begin
            per_cnt_q <= per_cnt_q + 26'h1;
        end
        tick_q <= nrst_i & tick;
    end

    // Command interpreter
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            widx_q <= 2'h0;
            cmd_q <= 8'h00;
            run_q <= 1'b1;
            stby_q <= 1'b0;
            cal_q <= 1'b0;
            filt_q <= 1'b0;
            orient_q <= `CMPCP_ORIENT_LEVEL;
            mode2_q <= `CMPCP_MODE2_RESET;
            upd_q <= 1'b0;
            for (int i = 0; i < 6; i++) resp_q[i] <= 8'h00;
        end else begin
            upd_q <= 1'b0;
            if (addr_wr) widx_q <= 2'h0;
            if (soft_rst) begin
                widx_q <= 2'h1;
                run_q <= 1'b1;
                stby_q <= 1'b0;
                cal_q <= 1'b0;
            end else if (wr_stb && widx_q == 2'h0) begin
                widx_q <= 2'h1;
                cmd_q <= cmd0;
                case (cmd0)
                    `CMPCP_CMD_HEAD: begin
                        {resp_q[0], resp_q[1]} <= ang_q.heading;
                        {resp_q[2], resp_q[3]} <= ang_q.pitch;
                        {resp_q[4], resp_q[5]} <= ang_q.roll;
                    end
                    `CMPCP_CMD_MODE1: resp_q[0] <= mode1;
                    `CMPCP_CMD_CAL_IN: cal_q <= ~sleep;
                    `CMPCP_CMD_CAL_OUT: begin
                        cal_q <= 1'b0;
                        upd_q <= cal_q;
                    end
                    `CMPCP_CMD_LEVEL: begin
                        orient_q <= `CMPCP_ORIENT_LEVEL;
                    end
                    `CMPCP_CMD_EDGE: begin
                        orient_q <= `CMPCP_ORIENT_EDGE;
                    end
                    `CMPCP_CMD_FRONT: begin
                        orient_q <= `CMPCP_ORIENT_FRONT;
                    end
                    `CMPCP_CMD_RUN: if (stby_q) begin
                        run_q <= 1'b1;
                        stby_q <= 1'b0;
                    end
                    `CMPCP_CMD_STBY: if (run_q) begin
                        run_q <= 1'b0;
                        stby_q <= 1'b1;
                    end
                    `CMPCP_CMD_SLEEP: if (run_q) run_q <= 1'b0;
                    `CMPCP_CMD_WAKE: stby_q <= stby_q | sleep;
                    default: ;
                endcase
            end else if (wr_stb && widx_q == 2'h1) begin
                widx_q <= 2'h2;
                if (cmd_q == `CMPCP_CMD_EE_RD) begin
                    resp_q[0] <= (sh_q == `CMPCP_EE_MODE1) ? mode1 :
                        (sh_q == `CMPCP_EE_MODE2) ? mode2_q : 8'h00;
                end
                resp_q[1] <= sh_q; // Holds the write address
            end else if (wr_stb && widx_q == 2'h2) begin
                widx_q <= 2'h3;
                if (cmd_q == `CMPCP_CMD_EE_WR &&
                    resp_q[1] == `CMPCP_EE_MODE1) begin
                    filt_q <= sh_q[`CMPCP_M1_FILT];
                    orient_q <= sh_q[2:0];
                end
                if (cmd_q == `CMPCP_CMD_EE_WR &&
                    resp_q[1] == `CMPCP_EE_MODE2) begin
                    mode2_q <= sh_q;
                end
            end
        end
    end

    // Angle capture with range limits
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ang_q <= '0;
        end else if (tick) begin
            ang_q.heading <= hsat;
            ang_q.pitch <= sat_tilt(angles_i.pitch);
            ang_q.roll <= sat_tilt(angles_i.roll);
        end
    end

    // Hard-iron offset: midpoint of extremes seen while calibrating
    for (genvar g = 0; g < 3; g++) begin : g_axis
        wire [15:0] m = mag_i.axis[g];
        wire [16:0] sum = {mx_q[g][15], mx_q[g]} + {mn_q[g][15], mn_q[g]};
        always_ff @(posedge clk_i) begin
            if (!nrst_i || !cal_q) begin
                mn_q[g] <= 16'h7fff;
                mx_q[g] <= 16'h8000;
            end else if (tick) begin
                if ($signed(m) < $signed(mn_q[g])) mn_q[g] <= m;
                if ($signed(m) > $signed(mx_q[g])) mx_q[g] <= m;
            end
            if (!nrst_i) begin
                off_q.axis[g] <= 16'h0000;
            end else if (upd_q) begin
                off_q.axis[g] <= sum[16:1];
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drv_q;
    assign meas_tick_o = tick_q;
    assign filter_en_o = filt_q;
    assign cal_active_o = cal_q;
    assign offset_update_o = upd_q;
    assign mag_offset_o = off_q;
    assign init_done_o = done_q;
    assign mode1_o = mode1;
    assign mode2_o = mode2_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_cmd(logic [7:0] c);
        wr_stb && widx_q == 2'h0 && cmd0 == c;
    endsequence
    a_orient_onehot: assert property ($onehot(orient_q))
        else $error("orientation not one-hot");
    a_cal_enter: assert property (
        s_cmd(`CMPCP_CMD_CAL_IN) ##0 run_q |=> mode1_o[6] && !mode1_o[7])
        else $error("calibration flag not set");
    a_cal_exit: assert property (
        s_cmd(`CMPCP_CMD_CAL_OUT) ##0 cal_q
        |=> offset_update_o && !cal_active_o ##1 !offset_update_o)
        else $error("offset update missing");
    a_wake_stby: assert property (
        s_cmd(`CMPCP_CMD_WAKE) ##0 sleep |=> mode1_o[4:3] == 2'h1)
        else $error("wake not into standby");
    a_run_enter: assert property (
        s_cmd(`CMPCP_CMD_RUN) ##0 stby_q
        |=> mode1_o[4:3] == 2'h2 && mode1_o[7])
        else $error("run not entered");
    a_init_nack: assert property (
        (st_q == CMPCP_ADDR) && byte_end && !done_q |=> sda_oe_n_o[*2])
        else $error("answered during init");
    a_addr_ack: assert property (addr_wr |=> !sda_oe_n_o)
        else $error("address ack missing");
    a_ack_held: assert property (
        st_q == CMPCP_ACK |-> !sda_oe_n_o)
        else $error("ack released early");
    a_ack_release: assert property (
        st_q == CMPCP_ACK && fall && !is_rd_q |=> sda_oe_n_o)
        else $error("ack held past ninth clock");
    a_angle_range: assert property (
        ang_q.heading <= `CMPCP_HEAD_MAX
        && $signed(ang_q.pitch) <= `CMPCP_TILT_MAX)
        else $error("angle out of range");
    a_rate_tick: assert property (tick |=> !tick [*8])
        else $error("measurement ticks too close");
endmodule : cmpcp_top

//--- verif/cmpcp_host.sv
// Purpose: I2C host model driving the compass command port
// Assumes: Open-drain bus with pull-up, resolved in the bench
// Notes: SCL runs only inside frames, 160 ns per bit
`timescale 1ns/1ns
module cmpcp_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_n_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    // Data moves 1 clk after SCL fall, sampled late in the high phase
    task automatic slot(input logic b, output logic s);
        tick(1);
        sda_oe_n_o = b;
        tick(3);
        scl_o = 1'b1;
        tick(3);
        s = sda_i;
        tick(1);
        scl_o = 1'b0;
    endtask : slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], s);
        end
        slot(1'b1, s);
        ack = ~s;
    endtask : wbyte
    task automatic frame_start();
        tick(2);
        sda_oe_n_o = 1'b0; // SDA falls while SCL high
        tick(4);
        scl_o = 1'b0;
    endtask : frame_start
    task automatic frame_stop();
        tick(1);
        sda_oe_n_o = 1'b0;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_oe_n_o = 1'b1;
        tick(4);
    endtask : frame_stop
    task automatic send(input logic [7:0] a, c, a1, a2, input int n,
                        output logic ok);
        logic ack;
        logic [7:0] b [4];
        b = '{a, c, a1, (c == 8'hf1 && a1 == 8'h05) ? a2 & 8'h03 : a2};
        ok = 1'b0;
        frame_start();
        for (int i = 0; i <= n; i++) begin
            wbyte(b[i], ack);
            if (i == 0) ok = ack;
        end
        frame_stop();
        tick(60); // Scaled response and settling wait
    endtask : send
    task automatic fetch(input int n, output logic [47:0] q);
        logic s;
        logic [7:0] d;
        q = '0;
        frame_start();
        wbyte(8'h33, s);
        for (int i = 0; i < n; i++) begin
            for (int k = 7; k >= 0; k--) begin
                slot(1'b1, s);
                d[k] = s;
            end
            slot(i == n - 1, s); // Last byte is NACKed to end the read
            q = {q[39:0], d};
        end
        frame_stop();
    endtask : fetch
endmodule : cmpcp_host

//--- verif/tb_top.sv
// Purpose: Self-checking bench of the compass command port
// Assumes: Short init and rate periods set by parameter
// Notes: Mode model kept in bench variables, compared after each command
`timescale 1ns/1ns
module tb_top;
    import cmpcp_pkg::*;
    localparam int P1 = 100;
    localparam int P5 = 40;
    localparam int P10 = 20;
    localparam logic [7:0] CMDS [11] = '{8'h73, 8'h74, 8'h72, 8'h76,
        8'h75, 8'h75, 8'h83, 8'h71, 8'h75, 8'h84, 8'h75};
    logic clk_i, nrst_i, scl, sda, sda_o, sda_oe_n, host_oe_n, ok;
    logic meas_tick, filter_en, cal_active, offset_update, init_done;
    logic [7:0] mode1, mode2;
    logic [47:0] q;
    cmpcp_angles_type angles;
    cmpcp_mag_type mag, mag_offset, exp_off;
    logic run = 1, stby = 0, cal = 0, filt = 0, slp = 0;
    logic [2:0] ori = 3'h1;
    int errors = 0, samples_checked = 0, updates = 0;
    // Open drain with pull-up: any party pulling low wins
    assign sda = host_oe_n & (sda_oe_n | sda_o);
    cmpcp_top #(.INIT_CYC(200), .P1_CYC(P1), .P5_CYC(P5), .P10_CYC(P10)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .angles_i(angles),
        .mag_i(mag), .meas_tick_o(meas_tick), .filter_en_o(filter_en),
        .cal_active_o(cal_active), .offset_update_o(offset_update),
        .mag_offset_o(mag_offset), .init_done_o(init_done),
        .mode1_o(mode1), .mode2_o(mode2));
    cmpcp_host host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_oe_n_o(host_oe_n));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (offset_update === 1'b1) updates++;
    function automatic logic [7:0] m1();
        return {run & ~cal, cal, filt, run, stby, ori};
    endfunction : m1
    task automatic results();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [47:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_sig(input int w, input int lim);
        int n;
        logic s;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
            s = (w == 0) ? init_done : meas_tick;
        end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) begin
            chk(48'h0, 48'h1);
            results();
        end
    endtask : wait_sig
    task automatic period(input int exp);
        int n;
        wait_sig(1, 300);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (meas_tick !== 1'b1 && n < 300);
        chk(48'(n), 48'(exp));
    endtask : period
    task automatic cmd(input logic [7:0] c);
        host.send(8'h32, c, 8'h00, 8'h00, 1, ok);
        if (!slp || c == 8'h84) begin
            case (c)
                8'h72: ori = 3'h1;
                8'h73: ori = 3'h2;
                8'h74: ori = 3'h4;
                8'h75: if (stby) {run, stby} = 2'b10;
                8'h76: if (run) {run, stby} = 2'b01;
                8'h83: if (run) {run, stby, slp} = 3'b001;
                8'h84: if (slp) {run, stby, slp} = 3'b010;
                8'h71: cal = 1'b1;
                8'h7e: cal = 1'b0;
                default: ;
            endcase
        end
        chk({cal_active, mode1}, {cal, m1()});
    endtask : cmd
    initial begin
        repeat (100000) @(posedge clk_i);
        chk(48'h0, 48'h1);
        results();
    end
    initial begin
        logic [15:0] v;
        int h, pt, rl, x, lo[3], hi[3];
        nrst_i = 1'b0;
        angles = '0;
        mag = '0;
        void'($urandom(33881));
        repeat (4) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        chk({mode1, mode2, sda_oe_n}, 17'h02203);
        host.send(8'h32, 8'h00, 8'h00, 8'h00, 0, ok);
        chk(ok, 1'b0);
        wait_sig(0, 400);
        chk(mode1, m1());
        host.send(8'h40, 8'h50, 8'h00, 8'h00, 1, ok);
        chk(ok, 1'b0);
        for (int i = 0; i < 4; i++) begin
            h = (i == 0) ? 4000 : $urandom_range(3600);
            pt = (i == 0) ? -1000 : $urandom_range(1800) - 900;
            rl = (i == 0) ? 1000 : $urandom_range(1800) - 900;
            angles = {16'(h), 16'(pt), 16'(rl)};
            wait_sig(1, 200);
            wait_sig(1, 200); // Fresh sample per poll
            host.send(8'h32, 8'h50, 8'h00, 8'h00, 1, ok);
            host.fetch(6, q);
            h = (h > 3600) ? 3600 : h;
            pt = (pt > 900) ? 900 : (pt < -900) ? -900 : pt;
            rl = (rl > 900) ? 900 : (rl < -900) ? -900 : rl;
            chk(q, {16'(h), 16'(pt), 16'(rl)});
        end
        foreach (CMDS[i]) cmd(CMDS[i]);
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 3; j++) begin
                v = 16'($urandom) & 16'hfffe;
                mag.axis[j] = v;
                x = int'($signed(v));
                lo[j] = (k == 0 || x < lo[j]) ? x : lo[j];
                hi[j] = (k == 0 || x > hi[j]) ? x : hi[j];
            end
            if (k == 0) cmd(8'h71);
            wait_sig(1, 200);
            wait_sig(1, 200);
        end
        updates = 0;
        cmd(8'h7e);
        foreach (lo[j]) exp_off.axis[j] = 16'((lo[j] + hi[j]) / 2);
        chk(mag_offset, exp_off);
        chk(48'(updates), 48'h1);
        host.send(8'h32, 8'hf1, 8'h04, 8'hca, 3, ok);
        {filt, ori} = 4'h2;
        chk(mode1, m1());
        host.send(8'h32, 8'hf1, 8'h04, 8'h21, 3, ok);
        {filt, ori} = 4'h9;
        host.send(8'h32, 8'he1, 8'h04, 8'h00, 2, ok);
        host.fetch(1, q);
        chk({filter_en, q[7:0]}, {filt, m1()});
        angles.heading = 16'h0bb8;
        repeat (40) wait_sig(1, 200);
        angles.heading = 16'h0000; // Filtered heading must lag this step
        for (int s = 0; s < 2; s++) begin
            host.send(8'h32, 8'h50, 8'h00, 8'h00, 1, ok);
            host.fetch(6, q);
            v = q[47:32];
            chk(48'(s ? v == 0 : v inside {[1:2999]}), 48'h1);
            repeat (40) wait_sig(1, 200);
        end
        for (int r = 0; r < 3; r++) begin
            host.send(8'h32, 8'hf1, 8'h05, 8'(r) | 8'hfc, 3, ok);
            host.send(8'h32, 8'he1, 8'h05, 8'h00, 2, ok);
            host.fetch(1, q);
            chk({mode2, q[7:0]}, {8'(r), 8'(r)});
            period((r == 0) ? P1 : (r == 1) ? P5 : P10);
        end
        results();
    end
endmodule : tb_top
